// ### rtl/t4f_pkg.sv
// Purpose: Shared constants for the timer 4 flag, enable and value register block
// Assumes: Word-addressed register bus, one 8-bit register per word index
// Notes:   Register indices equal the byte offsets of the 8-bit register map
package t4f_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FLAGS    = 8'h39;
  localparam logic [7:0] IDX_ENABLES  = 8'h72;
  localparam logic [7:0] IDX_CAP_HIGH = 8'ha7;
  localparam logic [7:0] IDX_CNT_LOW  = 8'h80;
  localparam logic [7:0] IDX_CNT_HIGH = 8'h81;
  localparam logic [7:0] IDX_CMP_LOW  = 8'h82;
  localparam logic [7:0] IDX_CMP_STEP = 8'h02;
  localparam logic [7:0] IDX_CAP_LOW  = 8'h88;
  localparam logic [7:0] IDX_CTRL     = 8'h89;
  localparam logic [7:0] IDX_FORCE    = 8'h8a;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OVF      = 0;
  localparam int unsigned BIT_MATCH_A  = 1;
  localparam int unsigned BIT_CAP      = 5;
  localparam logic [7:0]  ENABLES_MASK = 8'h2f;
  localparam int unsigned CTRL_RUN_BIT = 4;
  localparam logic [7:0]  CTRL_MASK    = 8'h1f;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CAP_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Waveform mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL  = 4'h0;
  localparam logic [3:0] MODE_CTC_A   = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hc;

  typedef enum logic {T4F_BUS_IDLE, T4F_BUS_ANSWER} t4f_bus_t;

endpackage

// ### rtl/t4f_cmp_unit.sv
// Purpose: One compare channel: 16-bit compare value and its match detector
// Assumes: tick is high in each cycle in which the counter advances
// Notes:   match is combinational; the flag register downstream adds the delay
module t4f_cmp_unit
  import t4f_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_value,
  input  wire logic [W-1:0] count,
  input  wire logic         tick,
  input  wire logic         block,
  output logic      [W-1:0] cmp_q,
  output logic              match
);

  // ----------------------------------------------------------------
  // Compare value
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= '0;
    end else if (wr_en) begin
      cmp_q <= wr_value;
    end
  end

  // ----------------------------------------------------------------
  // Match detect
  // ----------------------------------------------------------------
  // Compared on every timer clock, blocked after a counter write
  assign match = tick & ~block & (count == cmp_q);

endmodule

// ### rtl/t4f_flags_regs.sv
// Purpose: Timer 4 event flags, event enables, counter, compare and capture registers
// Assumes: Avalon-MM slave, word addressed, one 8-bit register in the low byte of a word
// Notes:   One wait state per access; waitrequest is high whenever no answer is due
//
// Overview of operation
// - Each compare value is compared with the running counter and a match can raise a request.
// - All 16-bit values pass through one shared high-byte holding latch so both bytes move at once.
// - The capture value is never loaded from the counter and always holds zero.
// - Reserved bits of the flag and enable registers read zero and ignore writes.
// - The capture enable and capture flag at bit 5 do nothing because there is no capture input.
// - A channel match request is raised only with its enable, the global flag and its match flag set.
// - The overflow request is raised only with its enable, the global flag and the overflow flag set.
// - A match flag is set in the timer clock cycle after the counter equals the compare value.
// - A force strobe never sets a match flag.
// - A match flag clears when its interrupt vector is executed.
// - Writing one to a flag clears it and writing zero leaves it alone.
// - The overflow flag sets when the counter wraps in normal and clear-on-match modes.
// - The overflow flag clears when its interrupt vector is executed.
// - A counter write blocks compare matches on all channels for the next timer clock.
// - A force strobe acts only in non-PWM modes, raises no request and never clears the counter.
module t4f_flags_regs
  import t4f_pkg::*;
#(
  parameter int unsigned CW = 16,
  parameter int unsigned NCH = 3
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic [7:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          global_irq_enable,
  input  wire logic [NCH:0]  vector_ack,
  output logic      [NCH:0]  irq_request,
  output logic      [NCH-1:0] force_event
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  t4f_bus_t          bus_q;
  logic [31:0]       rdata_q;
  logic [7:0]        rd_val;
  logic              acc;
  logic              rd_take;
  logic              do_wr;
  logic [7:0]        wbyte;
  logic [7:0]        temp_q;
  logic [7:0]        enables_q;
  logic [NCH:0]      flags_q;
  logic [NCH:0]      flags_d;
  logic [NCH:0]      events;
  logic [NCH:0]      clr_w;
  logic [7:0]        ctrl_q;
  logic [3:0]        mode;
  logic              run;
  logic              non_pwm;
  logic [CW-1:0]     count_q;
  logic [CW-1:0]     top;
  logic              cnt_wr;
  logic              tick;
  logic              block_q;
  logic              ovf_ev;
  logic [CW-1:0]     cmp_val [NCH];
  logic [NCH-1:0]    match;
  logic [NCH-1:0]    force_q;
  logic [CW-1:0]     capture;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // A request waits one cycle; writes take effect at the answer edge, reads at the waiting edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= T4F_BUS_IDLE;
    end else begin
      case (bus_q)
        T4F_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= T4F_BUS_ANSWER;
          end
        end
        T4F_BUS_ANSWER: begin
          bus_q <= T4F_BUS_IDLE;
        end
        default: begin
          bus_q <= T4F_BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = (bus_q != T4F_BUS_ANSWER);
  assign acc             = (bus_q == T4F_BUS_ANSWER);
  // Both bytes of a 16-bit read are taken at one edge, so a running count reads whole
  assign rd_take         = ~acc & avs_read;
  assign do_wr           = acc & avs_write & avs_byteenable[0];
  assign wbyte           = avs_writedata[7:0];

  // Read data is caught while waitrequest is high and held through the answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (rd_take) begin
      rdata_q <= {24'h000000, rd_val};
    end
  end

  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (avs_address == IDX_FLAGS) begin
      // Capture flag and reserved bits are not stored and read zero
      rd_val = {4'h0, flags_q};
    end else if (avs_address == IDX_ENABLES) begin
      rd_val = enables_q & ENABLES_MASK;
    end else if (avs_address == IDX_CNT_LOW) begin
      rd_val = count_q[7:0];
    end else if (avs_address == IDX_CAP_LOW) begin
      rd_val = capture[7:0];
    end else if (avs_address == IDX_CNT_HIGH || avs_address == IDX_CAP_HIGH) begin
      rd_val = temp_q;
    end else if (avs_address == IDX_CTRL) begin
      rd_val = ctrl_q;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (avs_address == 8'(IDX_CMP_LOW + IDX_CMP_STEP * i)) begin
          rd_val = cmp_val[i][7:0];
        end else if (avs_address == 8'(IDX_CMP_LOW + IDX_CMP_STEP * i + 1)) begin
          rd_val = temp_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared high-byte latch
  // ----------------------------------------------------------------
  // Low-byte reads park the high byte here; high-byte writes stage it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= REG_RESET;
    end else if (rd_take && avs_address == IDX_CNT_LOW) begin
      temp_q <= count_q[15:8];
    end else if (rd_take && avs_address == IDX_CAP_LOW) begin
      temp_q <= capture[15:8];
    end else if (do_wr && avs_address == IDX_CNT_HIGH) begin
      temp_q <= wbyte;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (rd_take && avs_address == 8'(IDX_CMP_LOW + IDX_CMP_STEP * i)) begin
          temp_q <= cmp_val[i][15:8];
        end else if (do_wr && avs_address == 8'(IDX_CMP_LOW + IDX_CMP_STEP * i + 1)) begin
          temp_q <= wbyte;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and enables
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= REG_RESET;
    end else if (do_wr && avs_address == IDX_CTRL) begin
      ctrl_q <= wbyte & CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_q <= REG_RESET;
    end else if (do_wr && avs_address == IDX_ENABLES) begin
      // Capture enable is stored but steers nothing
      enables_q <= wbyte & ENABLES_MASK;
    end
  end

  assign mode    = ctrl_q[3:0];
  assign run     = ctrl_q[CTRL_RUN_BIT];
  assign non_pwm = (mode == MODE_NORMAL) || (mode == MODE_CTC_A) || (mode == MODE_CTC_CAP);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Capture has no input pin, so its value is a constant
  assign capture = CAP_RESET;
  assign cnt_wr  = do_wr && (avs_address == IDX_CNT_LOW);
  // A counter write takes the place of that cycle's count step
  assign tick    = run & ~cnt_wr;

  always_comb begin
    top = CNT_MAX;
    if (mode == MODE_CTC_A) begin
      top = cmp_val[0];
    end else if (mode == MODE_CTC_CAP) begin
      top = capture;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= CNT_RESET;
    end else if (cnt_wr) begin
      count_q <= {temp_q, wbyte};
    end else if (tick) begin
      if (count_q == top) begin
        count_q <= CNT_RESET;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // Wrap past the maximum in any mode; only normal and clear-on-match are defined
  assign ovf_ev = tick & (count_q == CNT_MAX);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic cmp_wr;
    assign cmp_wr = do_wr && (avs_address == 8'(IDX_CMP_LOW + IDX_CMP_STEP * g));
    t4f_cmp_unit #(
      .W        (CW)
    ) u_cmp (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (cmp_wr),
      .wr_value ({temp_q, wbyte}),
      .count    (count_q),
      .tick     (tick),
      .block    (block_q),
      .cmp_q    (cmp_val[g]),
      .match    (match[g])
    );
  end

  // ----------------------------------------------------------------
  // Force strobes
  // ----------------------------------------------------------------
  // No pin is driven, so the strobe only shows on force_event
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_q <= '0;
    end else if (do_wr && avs_address == IDX_FORCE && non_pwm) begin
      force_q <= wbyte[NCH-1:0];
    end else begin
      force_q <= '0;
    end
  end

  // Strobes feed neither flags nor the counter
  assign force_event = force_q;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign events = {match, ovf_ev};
  assign clr_w  = (do_wr && avs_address == IDX_FLAGS) ? wbyte[NCH:0] : '0;

  // Set wins over both write-one clear and vector acknowledge
  assign flags_d = events | (flags_q & ~clr_w & ~vector_ack);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign irq_request = flags_q & enables_q[NCH:0] & {(NCH+1){global_irq_enable}};

endmodule

// ### tb/t4f_flags_regs_properties.sv
// Purpose: Port-level properties of the timer 4 register block
// Assumes: One clock, async active-low reset
// Notes:   Sees only the top module's ports
module t4f_flags_regs_chk
  import t4f_pkg::*;
#(
  parameter int unsigned CW  = 16,
  parameter int unsigned NCH = 3
) (
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire logic [7:0]     avs_address,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  input wire logic           global_irq_enable,
  input wire logic [NCH:0]   irq_request,
  input wire logic [NCH-1:0] force_event
);
  // ----------------------------------------
  // Bus and request properties
  // ----------------------------------------
  logic rq;
  logic rd_ans;
  assign rq     = avs_read | avs_write;
  assign rd_ans = avs_read & ~avs_waitrequest;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wait_state_a: assert property ($rose(rq) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not after one wait state");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  idle_wait_a: assert property (!rq |-> avs_waitrequest)
    else $error("answer without request");
  upper_zero_a: assert property (rd_ans |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  cap_zero_a: assert property (rd_ans && avs_address == IDX_CAP_LOW |-> avs_readdata == 0)
    else $error("capture low not zero");
  rsv_bits_a: assert property (rd_ans && avs_address == IDX_FLAGS |-> avs_readdata[7:4] == 0)
    else $error("reserved flag bits set");
  irq_gate_a: assert property (!global_irq_enable |-> irq_request == 0)
    else $error("request without global flag");
  force_pulse_a: assert property (force_event != 0 |=> force_event == 0)
    else $error("force strobe longer than one cycle");
  force_cause_a: assert property (force_event != 0 |->
      $past(avs_write && !avs_waitrequest && avs_address == IDX_FORCE))
    else $error("force strobe without force write");
endmodule
bind t4f_flags_regs t4f_flags_regs_chk #(.CW(CW), .NCH(NCH)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_irq_enable(global_irq_enable), .irq_request(irq_request),
  .force_event(force_event));

// ### tb/timer4_interrupt_flags_regs_tb.sv
// Purpose: Self-checking bench for the timer 4 register block
// Assumes: Counter stopped whenever flags are compared
// Notes:   Compare values sit well inside each run so bus timing cannot move them
module timer4_interrupt_flags_regs_tb
  import t4f_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic        global_irq_enable = 0;
  logic [7:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic [31:0] v;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [3:0]  vector_ack = 0;
  logic [3:0]  irq_request;
  logic [2:0]  force_event;
  logic        avs_waitrequest;
  int          bad_count = 0;
  int          n_tests = 0;
  integer      seed = 32'he4dd4f86;
  int          m_flags = 0;
  int          n_force = 0;
  logic [2:0]  force_or = 0;
  t4f_flags_regs dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .irq_request(irq_request), .force_event(force_event));
  always #50 core_clk = ~core_clk;
  // Force strobes last one cycle, so they are gathered at every edge
  always @(posedge core_clk) begin
    if (force_event != 0) begin
      n_force <= n_force + 1;
      force_or <= force_or | force_event;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; a stuck slave ends the run
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    int i;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      bad_count++;
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge core_clk);
  endtask
  // High byte first into the shared latch, low byte moves both
  task automatic w16(logic [7:0] a, logic [15:0] d);
    acc(1, a + 8'h01, d[15:8]);
    acc(1, a, d[7:0]);
  endtask
  task automatic rchk(string nm, logic [7:0] a, int exp);
    acc(0, a, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic ack(logic [3:0] b);
    vector_ack <= b;
    @(posedge core_clk);
    vector_ack <= 0;
    @(posedge core_clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rchk("flags rst", IDX_FLAGS, 0);
    rchk("en rst", IDX_ENABLES, 0);
    rchk("cap lo", IDX_CAP_LOW, 0);
    rchk("cap hi", IDX_CAP_HIGH, 0);
    acc(1, 8'hff, 8'h5a);
    rchk("unmapped", 8'hff, 0);
    avs_byteenable <= 4'h0;
    acc(1, IDX_ENABLES, 8'hff);
    avs_byteenable <= 4'h1;
    rchk("en no lane", IDX_ENABLES, 0);
    // Matches A, B, C while counting from 0x10
    w16(8'h82, 16'h0020);
    w16(8'h84, 16'h0030);
    w16(8'h86, 16'h0040);
    w16(8'h80, 16'h0010);
    acc(1, 8'h89, 8'h10);
    repeat (60) @(posedge core_clk);
    acc(1, 8'h89, 8'h00);
    acc(0, 8'h80, 8'h00);
    v[7:0] = rd[7:0];
    acc(0, 8'h81, 8'h00);
    v[15:8] = rd[7:0];
    chk("count span", 32'(v[15:0] > 16'h40 && v[15:0] < 16'h100), 1);
    m_flags = 32'h0e;
    rchk("flags match", IDX_FLAGS, m_flags);
    for (int g = 0; g < 2; g++) begin
      global_irq_enable <= g[0];
      v = $random(seed);
      acc(1, IDX_ENABLES, v[7:0]);
      rchk("en rw", IDX_ENABLES, v & 32'h2f);
      chk("irq", 32'(irq_request), m_flags & v & {28'h0, {4{g[0]}}});
    end
    acc(1, IDX_ENABLES, 8'h2f);
    acc(1, IDX_FLAGS, 8'hf4);
    m_flags = 32'h0a;
    rchk("w1c", IDX_FLAGS, m_flags);
    acc(1, IDX_FLAGS, 8'h00);
    rchk("w0 keeps", IDX_FLAGS, m_flags);
    ack(4'b0010);
    rchk("ack a", IDX_FLAGS, 32'h08);
    chk("irq c", 32'(irq_request), 32'h8);
    ack(4'b1000);
    rchk("ack c", IDX_FLAGS, 0);
    // Wrap from near the top, stopping before compare A
    w16(8'h80, 16'hfff0);
    acc(1, 8'h89, 8'h10);
    repeat (30) @(posedge core_clk);
    acc(1, 8'h89, 8'h00);
    rchk("ovf", IDX_FLAGS, 1);
    chk("irq ovf", 32'(irq_request), 1);
    ack(4'b0001);
    rchk("ack ovf", IDX_FLAGS, 0);
    // Counter written to the compare value while running: that match is lost
    w16(8'h82, 16'h1000);
    acc(1, 8'h89, 8'h10);
    w16(8'h80, 16'h1000);
    repeat (5) @(posedge core_clk);
    acc(1, 8'h89, 8'h00);
    acc(0, IDX_FLAGS, 8'h00);
    chk("blocked", rd & 32'h2, 0);
    // Running count read across the low-byte carry must come back whole
    w16(8'h80, 16'h00fe);
    acc(1, 8'h89, 8'h10);
    acc(0, 8'h80, 8'h00);
    v[7:0] = rd[7:0];
    acc(0, 8'h81, 8'h00);
    v[15:8] = rd[7:0];
    acc(1, 8'h89, 8'h00);
    chk("atomic rd", 32'(v[15:0] >= 16'h00fe && v[15:0] < 16'h0110), 1);
    acc(1, IDX_FLAGS, 8'hff);
    // A PWM mode ignores force strobes
    acc(1, 8'h89, 8'h01);
    acc(1, IDX_FORCE, 8'h07);
    acc(1, 8'h89, 8'h00);
    chk("pwm force", n_force, 0);
    acc(1, IDX_FORCE, 8'h07);
    rchk("force", IDX_FLAGS, 0);
    chk("force ev", force_or, 32'h7);
    chk("force n", n_force, 1);
    rchk("force rd", IDX_FORCE, 0);
    // Clear-on-match with compare A as top: count stays at or below it
    w16(8'h82, 16'h0008);
    w16(8'h80, 16'h0000);
    acc(1, 8'h89, 8'h14);
    repeat (20) @(posedge core_clk);
    acc(1, 8'h89, 8'h04);
    acc(0, 8'h80, 8'h00);
    v[7:0] = rd[7:0];
    acc(0, 8'h81, 8'h00);
    v[15:8] = rd[7:0];
    chk("ctc top", 32'(v[15:0] <= 16'h0008), 1);
    rchk("ctc flags", IDX_FLAGS, 32'h02);
    // Capture as top is zero, so the count never leaves zero
    w16(8'h80, 16'h0000);
    acc(1, 8'h89, 8'h1c);
    repeat (5) @(posedge core_clk);
    acc(1, 8'h89, 8'h0c);
    rchk("cap top", 8'h80, 0);
    rchk("cap end", IDX_CAP_LOW, 0);
    tally_and_finish();
  end
endmodule
